// ### rtl/bcs_pkg.sv
// package: shared constants and types for the bus-cycle stretch link
// assumes: one 10 MHz clock; both ends import this package
package bcs_pkg;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned MODE_W        = 5;
  localparam logic [31:0] RESET_VECTOR  = 32'h0000_0000;
  localparam logic [31:0] STEP_WORD     = 32'h0000_0004;
  localparam logic [31:0] STEP_HALF     = 32'h0000_0002;
  localparam logic [1:0]  POST_RST_IDLE = 2'h2;
  localparam logic [1:0]  PIPE_FILL     = 2'h3;
  localparam logic [1:0]  MIN_RST_CYC   = 2'h2;
  localparam logic [4:0]  MODE_USR      = 5'h10;
  localparam logic [4:0]  MODE_FIQ      = 5'h11;
  localparam logic [4:0]  MODE_IRQ      = 5'h12;
  localparam logic [4:0]  MODE_SVC      = 5'h13;
  localparam logic [4:0]  MODE_ABT      = 5'h17;
  localparam logic [4:0]  MODE_UND      = 5'h1B;
  localparam logic [4:0]  MODE_SYS      = 5'h1F;

  typedef enum logic [3:0] {
    BCS_RESET = 4'b0001,
    BCS_IDLE  = 4'b0010,
    BCS_FILL  = 4'b0100,
    BCS_RUN   = 4'b1000
  } bcs_state_e;

  function automatic logic [4:0] bcs_mode_inv(input logic [4:0] mode);
    return ~mode;
  endfunction

  function automatic logic bcs_mode_valid(input logic [4:0] mode);
    case (mode)
      MODE_USR, MODE_FIQ, MODE_IRQ, MODE_SVC, MODE_ABT, MODE_UND, MODE_SYS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
endpackage

// ### rtl/bcs_link_if.sv
// interface: core bus-cycle signals between the core end and the memory controller end
// assumes: both ends clocked by the same clk
`timescale 1ns/100ps
interface bcs_link_if;
  logic                        wait_n;
  logic                        abort;
  logic                        mem_request_n;
  logic                        sequential_access;
  logic                        user_translate_n;
  logic                        write;
  logic [bcs_pkg::ADDR_W-1:0]  addr;
  logic [bcs_pkg::DATA_W-1:0]  wdata;
  logic [bcs_pkg::DATA_W-1:0]  rdata;
  logic [bcs_pkg::MODE_W-1:0]  mode_out_inv;
  logic                        core_reset_n;
  logic                        test_reset_n;

  modport core (
    input  wait_n, abort, rdata, core_reset_n, test_reset_n,
    output mem_request_n, sequential_access, user_translate_n, write, addr, wdata,
           mode_out_inv
  );
  modport mem (
    output wait_n, abort, rdata, core_reset_n, test_reset_n,
    input  mem_request_n, sequential_access, user_translate_n, write, addr, wdata,
           mode_out_inv
  );
endinterface

// ### rtl/bcs_sync.sv
// two-flop synchroniser for pins entering the clock domain
// assumes: asynchronous active-low reset; first flop read only by second
`timescale 1ns/100ps
module bcs_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RESET_VAL;
      q_out  <= RESET_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// ### rtl/bcs_mem_end.sv
// memory controller end: inserts wait states, drives resets, answers reads
// assumes: core end on the same clock; user side issues requests below
`timescale 1ns/100ps
module bcs_mem_end
  import bcs_pkg::*;
#(
  parameter int unsigned WAIT_STATES = 1
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  bcs_link_if.mem                   link,
  input  wire logic                 sys_reset_req_in,
  input  wire logic                 abort_req_in,
  input  wire logic [DATA_W-1:0]    rdata_in,
  output logic [ADDR_W-1:0]         addr_out,
  output logic [DATA_W-1:0]         wdata_out,
  output logic                      write_out,
  output logic                      user_access_out,
  output logic                      access_done_out
);
  import bcs_pkg::*;

  logic [7:0]              wcnt_q, wcnt_d;
  logic                    wait_n_q, wait_n_d;
  logic [1:0]              rcnt_q, rcnt_d;
  logic                    rst_out_q, rst_out_d;
  logic                    pend_q, pend_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic                    wr_q, wr_d;
  logic                    usr_q, usr_d;
  logic [DATA_W-1:0]       wd_q, wd_d;
  logic                    done_q, done_d;

  // ========================================
  // reset source and wait-state generation
  always_comb begin
    rcnt_d    = rcnt_q;
    rst_out_d = rst_out_q;
    if (sys_reset_req_in) begin
      rcnt_d    = 2'h0;
      rst_out_d = 1'b0;
    end else if (rcnt_q < MIN_RST_CYC) begin
      rcnt_d    = rcnt_q + 2'h1;
    end else begin
      rst_out_d = 1'b1;
    end
    wcnt_d   = wcnt_q;
    wait_n_d = wait_n_q;
    pend_d   = pend_q;
    addr_d   = addr_q;
    wr_d     = wr_q;
    usr_d    = usr_q;
    wd_d     = wd_q;
    done_d   = 1'b0;
    // request class only looked at with wait high
    if (wait_n_q) begin
      if (pend_q) begin
        done_d = 1'b1;
        pend_d = 1'b0;
        // write data trails its address by one bus cycle
        wd_d   = link.wdata;
      end
      if (!link.mem_request_n && rst_out_q) begin
        pend_d   = 1'b1;
        addr_d   = link.addr;
        wr_d     = link.write;
        usr_d    = !link.user_translate_n;
        wcnt_d   = WAIT_STATES[7:0];
        wait_n_d = (WAIT_STATES == 0);
      end
    end else if (wcnt_q > 8'h1) begin
      wcnt_d = wcnt_q - 8'h1;
    end else begin
      wcnt_d   = 8'h0;
      wait_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rcnt_q    <= 2'h0;
      rst_out_q <= 1'b0;
      wcnt_q    <= 8'h0;
      wait_n_q  <= 1'b1;
      pend_q    <= 1'b0;
      addr_q    <= '0;
      wr_q      <= 1'b0;
      usr_q     <= 1'b0;
      wd_q      <= '0;
      done_q    <= 1'b0;
    end else begin
      rcnt_q    <= rcnt_d;
      rst_out_q <= rst_out_d;
      wcnt_q    <= wcnt_d;
      wait_n_q  <= wait_n_d;
      pend_q    <= pend_d;
      addr_q    <= addr_d;
      wr_q      <= wr_d;
      usr_q     <= usr_d;
      wd_q      <= wd_d;
      done_q    <= done_d;
    end
  end

  // test reset released with, never after, core reset
  assign link.core_reset_n = rst_out_q;
  assign link.test_reset_n = rst_out_q;
  assign link.wait_n       = wait_n_q;
  assign link.abort        = abort_req_in;
  assign link.rdata        = rdata_in;
  // mode lines ignored here: diagnostics only
  assign addr_out          = addr_q;
  assign wdata_out         = wd_q;
  assign write_out         = wr_q;
  assign user_access_out   = usr_q;
  assign access_done_out   = done_q;
endmodule

// ### rtl/bcs_core_end.sv
// core end: bus-cycle sequencing with wait stretch, reset sequence, mode outputs
// assumes: wait_n from same-clock logic; core_reset_n treated as a pin
`timescale 1ns/100ps
module bcs_core_end
  import bcs_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  bcs_link_if.core                  link,
  input  wire logic                 acc_valid_in,
  input  wire logic                 acc_write_in,
  input  wire logic                 acc_user_priv_in,
  input  wire logic [ADDR_W-1:0]    acc_addr_in,
  input  wire logic [DATA_W-1:0]    acc_wdata_in,
  input  wire logic                 step_half_in,
  input  wire logic [MODE_W-1:0]    status_mode_in,
  output logic                      acc_taken_out,
  output logic                      acc_done_out,
  output logic                      acc_abort_out,
  output logic [DATA_W-1:0]         acc_rdata_out,
  output logic                      first_exec_out,
  output logic                      in_reset_out
);
  import bcs_pkg::*;

  logic                 creset_s;
  logic                 advance;
  bcs_state_e           st_q, st_d;
  logic [1:0]           cnt_q, cnt_d;
  logic [ADDR_W-1:0]    addr_q, addr_d;
  logic [ADDR_W-1:0]    step_q, step_d;
  logic                 mreq_n_q, mreq_n_d;
  logic                 seq_q, seq_d;
  logic                 trans_n_q, trans_n_d;
  logic                 wr_q, wr_d;
  logic [DATA_W-1:0]    wd_q, wd_d;
  logic                 data_ph_q, data_ph_d;
  logic [MODE_W-1:0]    mode_inv_q, mode_inv_d;
  logic                 taken_q, taken_d;
  logic                 done_q, done_d;
  logic                 abort_q, abort_d;
  logic [DATA_W-1:0]    rdata_q, rdata_d;
  logic                 first_q, first_d;
  logic                 in_rst_q, in_rst_d;

  // ========================================
  // reset synchroniser
  bcs_sync #(.RESET_VAL(1'b0)) u_rst_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (link.core_reset_n),
    .q_out    (creset_s)
  );

  // wait is read unsynchronised: a sync delay would let a cycle end with wait low
  assign advance = link.wait_n;

  // ========================================
  // bus-cycle sequencer
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    addr_d     = addr_q;
    step_d     = step_q;
    mreq_n_d   = mreq_n_q;
    seq_d      = seq_q;
    trans_n_d  = trans_n_q;
    wr_d       = wr_q;
    wd_d       = wd_q;
    data_ph_d  = data_ph_q;
    mode_inv_d = mode_inv_q;
    taken_d    = 1'b0;
    done_d     = 1'b0;
    abort_d    = abort_q;
    rdata_d    = rdata_q;
    first_d    = 1'b0;
    in_rst_d   = !creset_s;
    // only legal modes are shown; others keep the last one
    if (bcs_mode_valid(status_mode_in)) begin
      mode_inv_d = bcs_mode_inv(status_mode_in);
    end
    if (!creset_s) begin
      // address keeps running from wherever the core stood
      st_d      = BCS_RESET;
      cnt_d     = 2'h0;
      mreq_n_d  = 1'b1;
      seq_d     = 1'b0;
      data_ph_d = 1'b0;
      step_d    = step_half_in ? STEP_HALF : STEP_WORD;
      addr_d    = addr_q + step_q;
    end else if (advance) begin
      if (data_ph_q) begin
        done_d  = 1'b1;
        abort_d = link.abort;
        rdata_d = link.rdata;
      end
      data_ph_d = !mreq_n_q;
      case (st_q)
        BCS_RESET: begin
          st_d  = BCS_IDLE;
          cnt_d = 2'h1;
        end
        BCS_IDLE: begin
          if (cnt_q >= POST_RST_IDLE) begin
            st_d     = BCS_FILL;
            cnt_d    = 2'h1;
            addr_d   = RESET_VECTOR;
            mreq_n_d = 1'b0;
            seq_d    = 1'b0;
            wr_d     = 1'b0;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
        BCS_FILL: begin
          addr_d   = addr_q + STEP_WORD;
          seq_d    = 1'b1;
          mreq_n_d = 1'b0;
          if (cnt_q >= PIPE_FILL) begin
            st_d    = BCS_RUN;
            first_d = 1'b1;
            mreq_n_d = 1'b1;
            seq_d    = 1'b0;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
        BCS_RUN: begin
          // next address goes out while this cycle's data moves
          mreq_n_d  = !acc_valid_in;
          seq_d     = acc_valid_in && !mreq_n_q && (acc_addr_in == addr_q + STEP_WORD);
          taken_d   = acc_valid_in;
          if (acc_valid_in) begin
            addr_d    = acc_addr_in;
            wr_d      = acc_write_in;
            trans_n_d = !acc_user_priv_in;
          end
          wd_d = wr_q ? acc_wdata_in : wd_q;
        end
        default: st_d = BCS_RESET;
      endcase
    end
  end

  // no dynamic state: a stall of any length holds every bus output except the mode lines
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q       <= BCS_RESET;
      cnt_q      <= 2'h0;
      addr_q     <= '0;
      step_q     <= STEP_WORD;
      mreq_n_q   <= 1'b1;
      seq_q      <= 1'b0;
      trans_n_q  <= 1'b1;
      wr_q       <= 1'b0;
      wd_q       <= '0;
      data_ph_q  <= 1'b0;
      mode_inv_q <= 5'h0C;
      taken_q    <= 1'b0;
      done_q     <= 1'b0;
      abort_q    <= 1'b0;
      rdata_q    <= '0;
      first_q    <= 1'b0;
      in_rst_q   <= 1'b1;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      addr_q     <= addr_d;
      step_q     <= step_d;
      mreq_n_q   <= mreq_n_d;
      seq_q      <= seq_d;
      trans_n_q  <= trans_n_d;
      wr_q       <= wr_d;
      wd_q       <= wd_d;
      data_ph_q  <= data_ph_d;
      mode_inv_q <= mode_inv_d;
      taken_q    <= taken_d;
      done_q     <= done_d;
      abort_q    <= abort_d;
      rdata_q    <= rdata_d;
      first_q    <= first_d;
      in_rst_q   <= in_rst_d;
    end
  end

  assign link.mem_request_n     = mreq_n_q;
  assign link.sequential_access = seq_q;
  assign link.user_translate_n  = trans_n_q;
  assign link.write             = wr_q;
  assign link.addr              = addr_q;
  assign link.wdata             = wd_q;
  assign link.mode_out_inv      = mode_inv_q;
  assign acc_taken_out          = taken_q;
  assign acc_done_out           = done_q;
  assign acc_abort_out          = abort_q;
  assign acc_rdata_out          = rdata_q;
  assign first_exec_out         = first_q;
  assign in_reset_out           = in_rst_q;
endmodule

// ### sim/bcs_link_props.sv
// checker: link properties between the core end and the memory end
// assumes: one clock domain; instantiated beside the link interface
`timescale 1ns/100ps
module bcs_link_props #(
  parameter int unsigned WAIT_STATES = 1
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       wait_n,
  input  wire logic                       mem_request_n,
  input  wire logic                       sequential_access,
  input  wire logic                       user_translate_n,
  input  wire logic                       write,
  input  wire logic [bcs_pkg::ADDR_W-1:0] addr,
  input  wire logic [bcs_pkg::DATA_W-1:0] wdata,
  input  wire logic [bcs_pkg::MODE_W-1:0] mode_out_inv,
  input  wire logic                       core_reset_n,
  input  wire logic                       test_reset_n
);
  import bcs_pkg::*;
  logic [7:0] low_cnt_q;
  logic [7:0] low_cnt_d;
  // ==========
  // stall length
  always_comb begin
    low_cnt_d = wait_n ? 8'h00 : low_cnt_q + 8'h01;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_q <= 8'h00;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // core syncs its reset pin over two edges, so look a few edges back
  sequence s_core_held;
    !core_reset_n && !$past(core_reset_n) && !$past(core_reset_n, 2)
      && !$past(core_reset_n, 3) && !$past(core_reset_n, 4);
  endsequence
  // reset reaches the core three edges late; wait acts at once
  sequence s_stalled;
    $past(core_reset_n, 3) && $past(core_reset_n, 4) && !$past(wait_n);
  endsequence
  sequence s_idle2;
    mem_request_n [*2];
  endsequence
  sequence s_fetch0;
    !mem_request_n && addr == RESET_VECTOR;
  endsequence
  AST_HOLD: assert property (s_stalled |-> $stable(addr) && $stable(wdata)
      && $stable(mem_request_n) && $stable(write) && $stable(user_translate_n))
    else $error("outputs moved in a stall");
  AST_RST_IDLE: assert property (s_core_held |-> mem_request_n && !sequential_access)
    else $error("memory cycle in reset");
  AST_RST_STEP: assert property (s_core_held ##0 $past(rst_n_in)
      |-> (addr - $past(addr)) inside {STEP_HALF, STEP_WORD})
    else $error("bad reset step");
  AST_BOOT: assert property ($rose(core_reset_n) |-> s_idle2 ##[1:8] s_fetch0)
    else $error("no fetch from zero");
  AST_RST_MIN: assert property ($fell(core_reset_n) |-> !core_reset_n [*2])
    else $error("short reset");
  AST_TEST_RST: assert property (!core_reset_n |-> !test_reset_n)
    else $error("test reset late");
  AST_MODE: assert property (mode_out_inv inside {5'h0F, 5'h0E, 5'h0D, 5'h0C,
      5'h08, 5'h04, 5'h00}) else $error("bad mode code");
  AST_WAIT_LEN: assert property (low_cnt_q <= WAIT_STATES + 2)
    else $error("stall too long");
endmodule

// ### sim/tb_bus_cycle_stretch_and_reset.sv
// testbench: both ends joined by the link, driven from their user sides
// assumes: 10 MHz clock; inputs change on the falling edge
`timescale 1ns/100ps
module tb_bus_cycle_stretch_and_reset;
  import bcs_pkg::*;
  localparam int unsigned WS  = 4;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic        clk_in;
  logic        rst_n_in;
  logic        acc_valid;
  logic        acc_write;
  logic        acc_user;
  logic [31:0] acc_addr;
  logic [31:0] acc_wdata;
  logic        step_half;
  logic [4:0]  status_mode;
  logic        sys_rst;
  logic        abort_req;
  logic [31:0] rdata;
  logic        taken;
  logic        done;
  logic        acc_abort;
  logic [31:0] acc_rdata;
  logic        first_exec;
  logic        in_reset;
  logic [31:0] m_addr;
  logic [31:0] m_wdata;
  logic        m_write;
  logic        m_user;
  logic        m_done;
  int          fails;
  int          check_count;
  int          cycles;
  bcs_link_if link_if ();
  bcs_core_end bcs_core_end_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_if.core),
    .acc_valid_in(acc_valid), .acc_write_in(acc_write), .acc_user_priv_in(acc_user),
    .acc_addr_in(acc_addr), .acc_wdata_in(acc_wdata), .step_half_in(step_half),
    .status_mode_in(status_mode), .acc_taken_out(taken), .acc_done_out(done),
    .acc_abort_out(acc_abort), .acc_rdata_out(acc_rdata), .first_exec_out(first_exec),
    .in_reset_out(in_reset));
  bcs_mem_end #(.WAIT_STATES(WS)) bcs_mem_end_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_if.mem),
    .sys_reset_req_in(sys_rst), .abort_req_in(abort_req), .rdata_in(rdata),
    .addr_out(m_addr), .wdata_out(m_wdata), .write_out(m_write),
    .user_access_out(m_user), .access_done_out(m_done));
  bcs_link_props #(.WAIT_STATES(WS)) bcs_link_props_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wait_n(link_if.wait_n),
    .mem_request_n(link_if.mem_request_n), .sequential_access(link_if.sequential_access),
    .user_translate_n(link_if.user_translate_n), .write(link_if.write),
    .addr(link_if.addr), .wdata(link_if.wdata), .mode_out_inv(link_if.mode_out_inv),
    .core_reset_n(link_if.core_reset_n), .test_reset_n(link_if.test_reset_n));
  // ==========
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_boot;
    int n;
    for (n = 0; n < 60 && link_if.mem_request_n !== 1'b0; n++) @(negedge clk_in);
    check(link_if.addr, RESET_VECTOR);
    for (n = 0; n < 60 && first_exec !== 1'b1; n++) @(negedge clk_in);
    // waits may stretch the fill, so three is a floor
    check(32'(n >= 3 && n < 60), ONE);
    check(32'(in_reset), 32'h0000_0000);
    repeat (4) @(negedge clk_in);
  endtask
  task automatic t_reset(input logic half, input logic [31:0] step);
    logic [31:0] a0;
    step_half = half;
    @(negedge clk_in);
    sys_rst = 1'b1;
    repeat (8) @(negedge clk_in);
    check(32'(in_reset), ONE);
    a0 = link_if.addr;
    @(negedge clk_in);
    check(link_if.addr - a0, step);
    check(32'(link_if.mem_request_n), ONE);
    sys_rst = 1'b0;
    t_boot();
  endtask
  task automatic t_modes;
    logic [4:0] md [8] = '{MODE_USR, MODE_FIQ, MODE_IRQ, MODE_SVC,
                           MODE_ABT, MODE_UND, MODE_SYS, 5'h15};
    logic [4:0] inv [8] = '{5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h08, 5'h04, 5'h00, 5'h00};
    for (int i = 0; i < 8; i++) begin
      status_mode = md[i];
      repeat (3) @(negedge clk_in);
      check(32'(link_if.mode_out_inv), 32'(inv[i]));
    end
  endtask
  task automatic t_access(input logic wr, input logic usr, input logic ab,
                          input logic [31:0] a, input logic [31:0] d);
    int n;
    acc_write = wr;
    acc_user = usr;
    acc_addr = a;
    acc_wdata = d;
    rdata = ~d;
    abort_req = ab;
    acc_valid = 1'b1;
    for (n = 0; n < 100 && taken !== 1'b1; n++) @(negedge clk_in);
    acc_valid = 1'b0;
    // a done pulse seen with taken belongs to the previous cycle
    @(negedge clk_in);
    for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clk_in);
    check(32'(n < 100), ONE);
    check(32'(m_done), ONE);
    @(negedge clk_in);
    check(m_addr, a);
    check(32'(m_write), 32'(wr));
    check(32'(m_user), 32'(usr));
    check(wr ? m_wdata : acc_rdata, wr ? d : ~d);
    check(32'(acc_abort), 32'(ab));
    abort_req = 1'b0;
    repeat (12) @(negedge clk_in);
  endtask
  // ==========
  // clock, timeout, main sequence
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      results();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_user = 1'b0;
    acc_addr = 32'h0000_0000;
    acc_wdata = 32'h0000_0000;
    step_half = 1'b0;
    status_mode = MODE_SVC;
    sys_rst = 1'b0;
    abort_req = 1'b0;
    rdata = 32'h0000_0000;
    fails = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_boot();
    t_modes();
    t_access(1'b1, 1'b0, 1'b0, 32'h0000_1000, 32'hA5A5_5A5A);
    t_access(1'b0, 1'b1, 1'b0, 32'h0000_2004, 32'h1234_5678);
    t_access(1'b0, 1'b0, 1'b1, 32'h0000_3008, 32'h0F0F_F0F0);
    t_reset(1'b1, STEP_HALF);
    t_reset(1'b0, STEP_WORD);
    t_access(1'b1, 1'b1, 1'b0, 32'hFFFF_FFFC, 32'h8000_0001);
    results();
  end
endmodule
